// >>> ept_consts.svh
// Purpose: register offsets, field positions and reset values of the pwm timer block
// Assumes: 8-bit special-function register bus
// Notes: definitions only
`ifndef EPT_CONSTS_SVH
`define EPT_CONSTS_SVH

// register addresses
`define EPT_ADDR_CFG 8'ha9
`define EPT_ADDR_EN 8'haa
`define EPT_ADDR_LDPOL 8'hab
`define EPT_ADDR_DATA 8'hac
`define EPT_ADDR_MODE 8'had
`define EPT_ADDR_CLKCFG 8'haf

// channel_access_config fields
`define EPT_CFG_HOLD 6
`define EPT_CFG_CLRALL 5
`define EPT_CFG_BYTE 4
`define EPT_CFG_VAL 3
`define EPT_CFG_CH_HI 2
`define EPT_CFG_WMASK 8'h5f

// reset values
`define EPT_RST_BYTE 8'h00
`define EPT_RST_WORD 16'h0000
`define EPT_RST_PRE 14'h0000

// prescale: codes at or above this divide by the same largest ratio
`define EPT_PRE_MAX 4'he

`endif

// >>> ept_pkg.sv
// Purpose: state types of the pwm timer block
// Assumes: eight channels of 16 bits
// Notes: one packed struct per module
package ept_pkg;

    // per-channel state
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] mid_act;
        logic [15:0] end_act;
        logic [15:0] mid_stg;
        logic [15:0] end_stg;
        logic pending;
        logic out;
    } ept_chan_t;

    // prescaler state
    typedef struct packed {
        logic [13:0] cnt;
        logic tick;
    } ept_pre_t;

    // register file state
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] en;
        logic [7:0] pol;
        logic [7:0] mode;
        logic [7:0] clkcfg;
        logic [7:0] rdata;
    } ept_regs_t;

endpackage : ept_pkg

// >>> ept_prescaler.sv
// Purpose: divides the system clock by two to the power of a 4-bit code
// Assumes: codes 14 and 15 both give the largest ratio
// Notes: tick_o is a one-cycle enable pulse
`timescale 1ns/1ps
`include "ept_consts.svh"

module ept_prescaler #(
    parameter int PRE_W = 14
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] div_i,
    output logic tick_o
);
    import ept_pkg::*;

    ept_pre_t s_reg;
    ept_pre_t s_next;

    // elaboration check: counter must match the state type
    if (PRE_W != 14) begin : g_chk
        $error("ept_prescaler: PRE_W must be 14");
    end

    // tick decode: low bits of the free counter all ones
    function automatic logic tick_due(input logic [13:0] c, input logic [3:0] d);
        logic [3:0] k;
        logic [13:0] mask;
        k = (d > `EPT_PRE_MAX) ? `EPT_PRE_MAX : d;
        for (int i = 0; i < 14; i++) begin
            mask[i] = (i < int'(k));
        end
        return (c & mask) == mask;
    endfunction : tick_due

    // next state
    always_comb begin
        s_next = s_reg;
        s_next.cnt = s_reg.cnt + 14'h0001;
        s_next.tick = tick_due(s_reg.cnt, div_i);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;

    a_div_one_tick: assert property (@(posedge clk_i) disable iff (!rstn_i)
        div_i == 4'h0 |=> tick_o)
        else $error("prescaler code zero gave no tick");

    a_div_two_alt: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (div_i == 4'h1)[*3] |-> tick_o != $past(tick_o))
        else $error("divide by two does not alternate");

endmodule : ept_prescaler

// >>> ept_channel.sv
// Purpose: one 16-bit pwm or timer channel with staged compare and terminal values
// Assumes: tick_i is a one-cycle enable from the group prescaler
// Notes: staged values move to the active pair together at the cycle end
`timescale 1ns/1ps
`include "ept_consts.svh"

module ept_channel (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic pol_i,
    input wire logic hold_i,
    input wire logic clear_i,
    input wire logic wr_i,
    input wire logic sel_end_i,
    input wire logic sel_msb_i,
    input wire logic [7:0] wdata_i,
    output logic [15:0] mid_stg_o,
    output logic [15:0] end_stg_o,
    output logic pending_o,
    output logic out_o
);
    import ept_pkg::*;

    ept_chan_t s_reg;
    ept_chan_t s_next;

    // next state
    always_comb begin
        logic wrap;
        wrap = 1'b0;
        s_next = s_reg;
        // count only when active and ticked
        if (enable_i && tick_i) begin
            wrap = (s_reg.cnt == s_reg.end_act);
            // roll over at the terminal value
            if (wrap) begin
                s_next.cnt = `EPT_RST_WORD;
                if (s_reg.pending && !hold_i) begin
                    s_next.mid_act = s_reg.mid_stg;
                    s_next.end_act = s_reg.end_stg;
                    s_next.pending = 1'b0;
                end
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
        end
        if (clear_i) begin
            s_next.cnt = `EPT_RST_WORD;
        end
        // byte write into staged value, set wins over load
        if (wr_i) begin
            if (sel_end_i && sel_msb_i) begin
                s_next.end_stg[15:8] = wdata_i;
            end else if (sel_end_i) begin
                s_next.end_stg[7:0] = wdata_i;
            end else if (sel_msb_i) begin
                s_next.mid_stg[15:8] = wdata_i;
            end else begin
                s_next.mid_stg[7:0] = wdata_i;
            end
            s_next.pending = 1'b1;
        end
        // start level, opposite once compare reached
        s_next.out = pol_i ^ (enable_i && (s_next.cnt >= s_next.mid_act));
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign mid_stg_o = s_reg.mid_stg;
    assign end_stg_o = s_reg.end_stg;
    assign pending_o = s_reg.pending;
    assign out_o = s_reg.out;

    a_wrap_to_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        enable_i && tick_i && s_reg.cnt == s_reg.end_act |=> s_reg.cnt == 16'h0000)
        else $error("counter did not wrap to zero");

    a_count_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
        enable_i && tick_i && !clear_i && s_reg.cnt != s_reg.end_act
        |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
        else $error("counter did not advance by one");

    a_inactive_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !enable_i && !clear_i |=> s_reg.cnt == $past(s_reg.cnt) && out_o == $past(pol_i))
        else $error("inactive channel moved");

    a_load_apply: assert property (@(posedge clk_i) disable iff (!rstn_i)
        enable_i && tick_i && s_reg.cnt == s_reg.end_act && s_reg.pending && !hold_i && !wr_i
        |=> !pending_o && s_reg.end_act == $past(end_stg_o) && s_reg.mid_act == $past(mid_stg_o))
        else $error("staged values not loaded at cycle end");

    a_hold_pending: assert property (@(posedge clk_i) disable iff (!rstn_i)
        hold_i && pending_o |=> pending_o)
        else $error("update applied while held");

    a_mid_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
        enable_i ##1 s_reg.cnt >= s_reg.mid_act |-> out_o == !$past(pol_i))
        else $error("output not at opposite level");

    a_clear_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        clear_i |=> s_reg.cnt == 16'h0000)
        else $error("counter not cleared");

endmodule : ept_channel

// >>> ept_top.sv
// Purpose: eight-channel pwm and timer block behind six special-function registers
// Assumes: register bus on clk_i, read data valid the cycle after the read strobe
// Notes: channels 0..3 and 4..7 each share one prescaler
`timescale 1ns/1ps
`include "ept_consts.svh"

module ept_top #(
    parameter int NCH = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic [7:0] pwm_o
);
    import ept_pkg::*;

    ept_regs_t s_reg;
    ept_regs_t s_next;

    logic [1:0] grp_tick;
    logic [7:0] ch_sel;
    logic [7:0] ch_wr;
    logic [7:0] ch_clear;
    logic [7:0] pending;
    logic [7:0] out;
    logic [15:0] mid_stg [8];
    logic [15:0] end_stg [8];
    logic clr_all;
    logic wr_cfg;
    logic wr_en;
    logic wr_ldpol;
    logic wr_data;
    logic wr_mode;
    logic wr_clk;

    // elaboration check: register widths fix the channel count
    if (NCH != 8) begin : g_chk
        $error("ept_top: NCH must be 8");
    end

    // one-hot channel decode from the index field
    function automatic logic [7:0] ch_decode(input logic [2:0] idx);
        return 8'h01 << idx;
    endfunction : ch_decode

    // byte of a staged value picked by the access fields
    function automatic logic [7:0] pick_byte(input logic [15:0] m, input logic [15:0] e,
                                             input logic [7:0] cfg);
        logic [15:0] w;
        w = cfg[`EPT_CFG_VAL] ? e : m;
        return cfg[`EPT_CFG_BYTE] ? w[15:8] : w[7:0];
    endfunction : pick_byte

    // write strobes
    assign wr_cfg = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_CFG);
    assign wr_en = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_EN);
    assign wr_ldpol = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_LDPOL);
    assign wr_data = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_DATA);
    assign wr_mode = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_MODE);
    assign wr_clk = sfr_wr_i && (sfr_addr_i == `EPT_ADDR_CLKCFG);

    // clear-all is a one-cycle pulse, never stored
    assign clr_all = wr_cfg && sfr_wdata_i[`EPT_CFG_CLRALL];

    assign ch_sel = ch_decode(s_reg.cfg[`EPT_CFG_CH_HI:0]);

    // data write routed to one channel
    assign ch_wr = wr_data ? ch_sel : 8'h00;

    assign ch_clear = {8{clr_all}} | ({8{wr_ldpol}} & sfr_wdata_i & s_reg.mode);

    // register file next state
    always_comb begin
        s_next = s_reg;
        // config keeps bit 7 and the clear-all bit at zero
        if (wr_cfg) begin
            s_next.cfg = sfr_wdata_i & `EPT_CFG_WMASK;
        end
        if (wr_en) begin
            s_next.en = sfr_wdata_i;
        end
        // start level written only for pwm-mode channels
        if (wr_ldpol) begin
            s_next.pol = (s_reg.pol & s_reg.mode) | (sfr_wdata_i & ~s_reg.mode);
        end
        if (wr_mode) begin
            s_next.mode = sfr_wdata_i;
        end
        if (wr_clk) begin
            s_next.clkcfg = sfr_wdata_i;
        end
        // read answer, unmapped reads zero
        if (sfr_rd_i) begin
            if (sfr_addr_i == `EPT_ADDR_CFG) begin
                s_next.rdata = s_reg.cfg;
            end else if (sfr_addr_i == `EPT_ADDR_EN) begin
                s_next.rdata = s_reg.en;
            end else if (sfr_addr_i == `EPT_ADDR_LDPOL) begin
                s_next.rdata = pending;
            // selected byte of the staged value
            end else if (sfr_addr_i == `EPT_ADDR_DATA) begin
                s_next.rdata = pick_byte(mid_stg[s_reg.cfg[`EPT_CFG_CH_HI:0]],
                                         end_stg[s_reg.cfg[`EPT_CFG_CH_HI:0]], s_reg.cfg);
            end else if (sfr_addr_i == `EPT_ADDR_MODE) begin
                s_next.rdata = s_reg.mode;
            end else if (sfr_addr_i == `EPT_ADDR_CLKCFG) begin
                s_next.rdata = s_reg.clkcfg;
            end else begin
                s_next.rdata = `EPT_RST_BYTE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sfr_rdata_o = s_reg.rdata;
    assign pwm_o = out;

    // one prescaler per group of four
    for (genvar g = 0; g < 2; g++) begin : g_pre
        ept_prescaler #(
            .PRE_W(14)
        ) ept_prescaler_i (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .div_i(s_reg.clkcfg[4*g+3:4*g]),
            .tick_o(grp_tick[g])
        );
    end

    for (genvar c = 0; c < 8; c++) begin : g_ch
        ept_channel ept_channel_i (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .tick_i(grp_tick[c/4]),
            .enable_i(s_reg.en[c]),
            .pol_i(s_reg.pol[c]),
            .hold_i(s_reg.cfg[`EPT_CFG_HOLD]),
            .clear_i(ch_clear[c]),
            .wr_i(ch_wr[c]),
            .sel_end_i(s_reg.cfg[`EPT_CFG_VAL]),
            .sel_msb_i(s_reg.cfg[`EPT_CFG_BYTE]),
            .wdata_i(sfr_wdata_i),
            .mid_stg_o(mid_stg[c]),
            .end_stg_o(end_stg[c]),
            .pending_o(pending[c]),
            .out_o(out[c])
        );
    end

    a_enable_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_en |=> s_reg.en == $past(sfr_wdata_i))
        else $error("enable register not updated");

    a_clrall_self: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_cfg |=> !s_reg.cfg[5] && !s_reg.cfg[7] && s_reg.cfg[4:0] == $past(sfr_wdata_i[4:0]))
        else $error("config register stored wrongly");

    a_pending_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `EPT_ADDR_LDPOL |=> sfr_rdata_o == $past(pending))
        else $error("load status read wrong");

    // data write marks the selected channel pending
    a_write_pending: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_data |=> (pending & $past(ch_sel)) == $past(ch_sel))
        else $error("data write did not stage");

    // timer-mode channels keep their start level on a polarity write
    a_timer_pol: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ldpol |=> (s_reg.pol & $past(s_reg.mode)) == ($past(s_reg.pol) & $past(s_reg.mode)))
        else $error("timer channel polarity changed");

    a_reset_regs: assert property (@(posedge clk_i)
        !rstn_i |=> s_reg.cfg == `EPT_RST_BYTE && s_reg.en == `EPT_RST_BYTE
            && s_reg.pol == `EPT_RST_BYTE && sfr_rdata_o == `EPT_RST_BYTE)
        else $error("register not zero after reset");

    a_reset_pins: assert property (@(posedge clk_i)
        !rstn_i |=> pwm_o == `EPT_RST_BYTE)
        else $error("channel output not low after reset");

    a_mode_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_mode |=> s_reg.mode == $past(sfr_wdata_i))
        else $error("mode register not updated");

    a_prescale_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_clk |=> s_reg.clkcfg == $past(sfr_wdata_i))
        else $error("prescale register not updated");

    a_hold_stored: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_cfg |=> s_reg.cfg[`EPT_CFG_HOLD] == $past(sfr_wdata_i[`EPT_CFG_HOLD]))
        else $error("hold bit not stored");

    a_read_low_mid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `EPT_ADDR_DATA && !s_reg.cfg[`EPT_CFG_BYTE]
            && !s_reg.cfg[`EPT_CFG_VAL]
            |=> sfr_rdata_o == $past(mid_stg[s_reg.cfg[2:0]][7:0]))
        else $error("compare low byte read wrong");

    a_read_high_mid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `EPT_ADDR_DATA && s_reg.cfg[`EPT_CFG_BYTE]
            && !s_reg.cfg[`EPT_CFG_VAL]
            |=> sfr_rdata_o == $past(mid_stg[s_reg.cfg[2:0]][15:8]))
        else $error("compare high byte read wrong");

    a_read_low_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `EPT_ADDR_DATA && !s_reg.cfg[`EPT_CFG_BYTE]
            && s_reg.cfg[`EPT_CFG_VAL]
            |=> sfr_rdata_o == $past(end_stg[s_reg.cfg[2:0]][7:0]))
        else $error("terminal low byte read wrong");

    a_read_high_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `EPT_ADDR_DATA && s_reg.cfg[`EPT_CFG_BYTE]
            && s_reg.cfg[`EPT_CFG_VAL]
            |=> sfr_rdata_o == $past(end_stg[s_reg.cfg[2:0]][15:8]))
        else $error("terminal high byte read wrong");

    a_index_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_data && s_reg.cfg[2:0] == 3'd0 |-> ch_wr == 8'h01)
        else $error("index zero routed wrongly");

    a_index_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_data && s_reg.cfg[2:0] == 3'd7 |-> ch_wr == 8'h80)
        else $error("index seven routed wrongly");

    a_write_low_mid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_data && !s_reg.cfg[`EPT_CFG_BYTE] && !s_reg.cfg[`EPT_CFG_VAL]
            |=> mid_stg[s_reg.cfg[2:0]][7:0] == $past(sfr_wdata_i))
        else $error("compare low byte not staged");

    a_write_high_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_data && s_reg.cfg[`EPT_CFG_BYTE] && s_reg.cfg[`EPT_CFG_VAL]
            |=> end_stg[s_reg.cfg[2:0]][15:8] == $past(sfr_wdata_i))
        else $error("terminal high byte not staged");

    a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i != `EPT_ADDR_CFG && sfr_addr_i != `EPT_ADDR_EN
            && sfr_addr_i != `EPT_ADDR_LDPOL && sfr_addr_i != `EPT_ADDR_DATA
            && sfr_addr_i != `EPT_ADDR_MODE && sfr_addr_i != `EPT_ADDR_CLKCFG
            |=> sfr_rdata_o == `EPT_RST_BYTE)
        else $error("unmapped read not zero");

    a_rdata_stands: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data changed without a read");

    a_pwm_mode_pol: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ldpol |=> (s_reg.pol & ~$past(s_reg.mode))
            == ($past(sfr_wdata_i) & ~$past(s_reg.mode)))
        else $error("pwm start level not written");

    // all disabled, pins at start level
    a_disabled_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_reg.en == `EPT_RST_BYTE |=> pwm_o == $past(s_reg.pol))
        else $error("disabled output not at start level");

endmodule : ept_top

// >>> ept_cpu_model.sv
// Purpose: processor model driving the special-function register bus
// Assumes: strobes pulse for one edge, read data registered one cycle later
// Notes: idle address and data lines show the inverse of the last value
`timescale 1ns/1ps

module ept_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);

    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one write, held until the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr

    // one read, data taken after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask : rd

endmodule : ept_cpu_model

// >>> test_eight_channel_pwm_timer.sv
// Purpose: self-checking bench of the eight-channel pwm timer
// Assumes: prescale codes 0..3 only, long ratios not exercised
// Notes: duty is measured as high cycles over whole periods
`timescale 1ns/1ps
`include "ept_consts.svh"

module test_eight_channel_pwm_timer;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } ept_row_t;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] pwm;
    logic [7:0] v;
    logic wr;
    logic rd;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    // address, write data, expected read back
    ept_row_t rows [9] = '{
        '{8'haa, 8'ha5, 8'ha5}, '{8'haa, 8'h00, 8'h00}, '{8'ha9, 8'hff, 8'h5f},
        '{8'ha9, 8'h00, 8'h00}, '{8'had, 8'hff, 8'hff}, '{8'had, 8'h00, 8'h00},
        '{8'haf, 8'h3c, 8'h3c}, '{8'haf, 8'h00, 8'h00}, '{8'ha0, 8'h77, 8'h00}};

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    ept_top ept_top_i (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .sfr_addr_i(addr),
        .sfr_wr_i(wr),
        .sfr_rd_i(rd),
        .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata),
        .pwm_o(pwm)
    );

    ept_cpu_model cpu_i (
        .clk_i(clk_i),
        .rdata_i(rdata),
        .addr_o(addr),
        .wr_o(wr),
        .rd_o(rd),
        .wdata_o(wdata)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cpu_i.rd(a, d);
        check(what, d, exp);
    endtask : rdchk

    // high cycles of one output over a window
    task automatic highs(input int n, input int len, output logic [7:0] h);
        h = 8'h00;
        repeat (len) begin
            @(posedge clk_i);
            #1;
            h = h + 8'(pwm[n]);
        end
    endtask : highs

    // load compare and terminal values of a channel byte by byte
    task automatic setv(input logic [2:0] c, input logic h, input logic [15:0] e,
                        input logic [15:0] m);
        logic [15:0] w;
        for (int k = 0; k < 4; k++) begin
            w = k[0] ? e : m;
            cpu_i.wr(`EPT_ADDR_CFG, {1'b0, h, 1'b0, k[1], k[0], c});
            cpu_i.wr(`EPT_ADDR_DATA, k[1] ? w[15:8] : w[7:0]);
        end
    endtask : setv

    task automatic results;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        check("pwm in reset", pwm, 8'h00);
        rstn_i = 1'b1;
        for (int a = 8'ha9; a <= 8'hac; a++) begin
            rdchk("reset value", 8'(a), 8'h00);
        end
        for (int i = 0; i < 9; i++) begin
            cpu_i.wr(rows[i].a, rows[i].d);
            rdchk("register", rows[i].a, rows[i].e);
        end
        // every byte of every channel staged
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                cpu_i.wr(`EPT_ADDR_CFG, 8'(c | (k << 3)));
                cpu_i.wr(`EPT_ADDR_DATA, 8'(c * 16 + k + 1));
            end
        end
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                cpu_i.wr(`EPT_ADDR_CFG, 8'(c | (k << 3)));
                rdchk("staged byte", `EPT_ADDR_DATA, 8'(c * 16 + k + 1));
            end
        end
        rdchk("pending all", `EPT_ADDR_LDPOL, 8'hff);
        setv(3'd0, 1'b0, 16'h0003, 16'h0001);
        cpu_i.wr(`EPT_ADDR_LDPOL, 8'h00);
        cpu_i.wr(`EPT_ADDR_EN, 8'h01);
        repeat (20) @(posedge clk_i);
        rdchk("pending ch0", `EPT_ADDR_LDPOL, 8'hfe);
        highs(0, 40, v);
        check("duty low start", v, 8'h1e);
        cpu_i.wr(`EPT_ADDR_LDPOL, 8'h01);
        repeat (10) @(posedge clk_i);
        highs(0, 40, v);
        check("duty high start", v, 8'h0a);
        cpu_i.wr(`EPT_ADDR_LDPOL, 8'h00);
        setv(3'd0, 1'b1, 16'h0007, 16'h0001);
        repeat (20) @(posedge clk_i);
        rdchk("held pending", `EPT_ADDR_LDPOL, 8'hff);
        highs(0, 40, v);
        check("held duty", v, 8'h1e);
        cpu_i.wr(`EPT_ADDR_CFG, 8'h00);
        repeat (20) @(posedge clk_i);
        rdchk("released", `EPT_ADDR_LDPOL, 8'hfe);
        highs(0, 80, v);
        check("new period", v, 8'h46);
        setv(3'd0, 1'b0, 16'h0003, 16'h0001);
        for (int n = 0; n < 4; n++) begin
            cpu_i.wr(`EPT_ADDR_CLKCFG, 8'(n));
            repeat (64 << n) @(posedge clk_i);
            highs(0, 32 << n, v);
            check("prescale", v, 8'(24 << n));
        end
        // second group on its own prescaler
        setv(3'd4, 1'b0, 16'h0003, 16'h0001);
        cpu_i.wr(`EPT_ADDR_EN, 8'h11);
        cpu_i.wr(`EPT_ADDR_CLKCFG, 8'h10);
        repeat (64) @(posedge clk_i);
        highs(4, 64, v);
        check("other group", v, 8'h30);
        highs(0, 32, v);
        check("first group", v, 8'h18);
        setv(3'd0, 1'b0, 16'h0007, 16'h0004);
        repeat (20) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (i) @(posedge clk_i);
            cpu_i.wr(`EPT_ADDR_CFG, 8'h20);
            repeat (2) @(posedge clk_i);
            #1;
            check("after clear", {7'h00, pwm[0]}, 8'h00);
        end
        // timer-mode clear at every phase, start level kept
        cpu_i.wr(`EPT_ADDR_MODE, 8'h01);
        for (int i = 0; i < 8; i++) begin
            repeat (i) @(posedge clk_i);
            cpu_i.wr(`EPT_ADDR_LDPOL, 8'h01);
            repeat (2) @(posedge clk_i);
            #1;
            check("timer clear", {7'h00, pwm[0]}, 8'h00);
        end
        cpu_i.wr(`EPT_ADDR_MODE, 8'h00);
        cpu_i.wr(`EPT_ADDR_LDPOL, 8'h01);
        cpu_i.wr(`EPT_ADDR_EN, 8'h00);
        repeat (5) @(posedge clk_i);
        highs(0, 20, v);
        check("disabled level", v, 8'h14);
        // reset in mid-run
        @(posedge clk_i);
        #1;
        rstn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check("pwm after reset", pwm, 8'h00);
        rstn_i = 1'b1;
        rdchk("pending after reset", `EPT_ADDR_LDPOL, 8'h00);
        rdchk("staged after reset", `EPT_ADDR_DATA, 8'h00);
        results();
    end

endmodule : test_eight_channel_pwm_timer
